// ==== verilog/gpm_port.sv ====
// seven-pin general purpose port with alternate function multiplexer
// Overview of operation
// - software writes each pin's output level
// - software reads each pin's sampled input
// - alternate function routes pin to peripheral
// - per-pin input stage enable control
// - disabled input stage reads as one
// - driver enable from software unless alternate
// - per-pin pull-up control
// - per-pin independent pull-down control
// - per-pin push-pull or open-drain select
// - seven pins, each own output/input bit
// - alt one outputs: spi tx, clk, fs, debug
// - alt two outputs: uart tx on 0, 2
// - alt three outputs: pwm on 0 to 2
// - alt one inputs: spi rx, clk, fs, debug
// - alt two inputs: uart rx, debug clock
// - alt three inputs connect nothing
module gpm_port (
  input wire logic clk,
  input wire logic rst,
  // software write strobes and data, one control word per kind
  input wire logic out_wr,
  input wire logic [6:0] out_wdata,
  input wire logic oe_wr,
  input wire logic [6:0] oe_wdata,
  input wire logic ie_wr,
  input wire logic [6:0] ie_wdata,
  input wire logic pu_wr,
  input wire logic [6:0] pu_wdata,
  input wire logic pd_wr,
  input wire logic [6:0] pd_wdata,
  input wire logic od_wr,
  input wire logic [6:0] od_wdata,
  input wire logic fsel_wr,
  input wire logic [13:0] fsel_wdata,
  // software view of state
  output logic [6:0] in_rdata,
  output logic [6:0] out_rdata,
  output logic [6:0] oe_rdata,
  output logic [6:0] ie_rdata,
  output logic [6:0] pu_rdata,
  output logic [6:0] pd_rdata,
  output logic [6:0] od_rdata,
  output logic [13:0] fsel_rdata,
  // pads
  input wire logic [6:0] pad_in,
  output logic [6:0] pad_out,
  output logic [6:0] pad_oe,
  output logic [6:0] pad_pu_en,
  output logic [6:0] pad_pd_en,
  output logic [6:0] pad_ie,
  // peripheral outputs toward pins
  input wire logic spi_txd,
  input wire logic spi_txd_oe,
  input wire logic spi_clk_out,
  input wire logic spi_clk_oe,
  input wire logic spi_fs_out,
  input wire logic spi_fs_oe,
  input wire logic dbg_data_out,
  input wire logic dbg_data_oe,
  input wire logic uart_txd,
  input wire logic uart_txd_oe,
  input wire logic pwm_out,
  input wire logic pwm_oe,
  // peripheral inputs from pins
  output logic spi_rxd,
  output logic serial_clock_input,
  output logic spi_fs_in,
  output logic dbg_data_in,
  output logic uart_rxd,
  output logic dbg_clk_in
);
  logic [6:0] out_q, oe_q, ie_q, pu_q, pd_q, od_q, in_q;
  logic [13:0] fsel_q;
  logic [6:0] alt_val, alt_oe, alt_sel, drv_val, drv_oe, pin_in;

  // checks sample on the rising edge; all but chk_reset_off rest during reset
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  // output level bits
  always_ff @(posedge clk) begin
    if (rst) out_q <= gpm_pkg::RST_OUT;
    else if (out_wr) out_q <= out_wdata;
  end

  // driver enable bits
  always_ff @(posedge clk) begin
    if (rst) oe_q <= gpm_pkg::RST_OE;
    else if (oe_wr) oe_q <= oe_wdata;
  end

  // input stage enable bits
  always_ff @(posedge clk) begin
    if (rst) ie_q <= gpm_pkg::RST_IE;
    else if (ie_wr) ie_q <= ie_wdata;
  end

  // pull resistor controls, independent of each other
  always_ff @(posedge clk) begin
    if (rst) begin
      pu_q <= gpm_pkg::RST_PULL;
      pd_q <= gpm_pkg::RST_PULL;
    end else begin
      if (pu_wr) pu_q <= pu_wdata;
      if (pd_wr) pd_q <= pd_wdata;
    end
  end

  // output type bits
  always_ff @(posedge clk) begin
    if (rst) od_q <= gpm_pkg::RST_OD;
    else if (od_wr) od_q <= od_wdata;
  end

  // function select, two bits per pin
  always_ff @(posedge clk) begin
    if (rst) fsel_q <= gpm_pkg::RST_FSEL;
    else if (fsel_wr) fsel_q <= fsel_wdata;
  end

  // gated pin level, reads one while input stage is off
  assign pin_in = pad_in | ~ie_q;

  // sampled input register
  always_ff @(posedge clk) begin
    if (rst) in_q <= gpm_pkg::RST_IN;
    else in_q <= pin_in;
  end

  // per-pin alternate output mux and driver stage
  for (genvar i = 0; i < gpm_pkg::NUM_PINS; i++) begin : g_pin
    gpm_pkg::gpm_fsel_t fs;
    logic a_val;
    logic a_oe;
    assign fs = gpm_pkg::gpm_fsel_t'(fsel_q[2*i +: 2]);
    // local mux keeps one writer per process; unused codes drive zero with the driver off
    always_comb begin
      a_val = 1'b0;
      a_oe = 1'b0;
      unique case (fs)
        gpm_pkg::GPM_FN_PRIMARY: begin
        end
        gpm_pkg::GPM_FN_ALT1: begin
          if (i == gpm_pkg::PIN_SPI_TXD) begin
            a_val = spi_txd;
            a_oe = spi_txd_oe;
          end else if (i == gpm_pkg::PIN_SPI_CLKO) begin
            a_val = spi_clk_out;
            a_oe = spi_clk_oe;
          end else if (i == gpm_pkg::PIN_SPI_FSO) begin
            a_val = spi_fs_out;
            a_oe = spi_fs_oe;
          end else if (i == gpm_pkg::PIN_DBG_DATA) begin
            a_val = dbg_data_out;
            a_oe = dbg_data_oe;
          end
        end
        gpm_pkg::GPM_FN_ALT2: begin
          if (i == gpm_pkg::PIN_UART_TX_A ||
              i == gpm_pkg::PIN_UART_TX_B) begin
            a_val = uart_txd;
            a_oe = uart_txd_oe;
          end
        end
        gpm_pkg::GPM_FN_ALT3: begin
          if (i <= gpm_pkg::PIN_PWM_LAST) begin
            a_val = pwm_out;
            a_oe = pwm_oe;
          end
        end
      endcase
    end
    assign alt_val[i] = a_val;
    assign alt_oe[i] = a_oe;
    assign alt_sel[i] = (fs != gpm_pkg::GPM_FN_PRIMARY);
    // primary path or peripheral path
    assign drv_val[i] = alt_sel[i] ? alt_val[i] : out_q[i];
    assign drv_oe[i] = alt_sel[i] ? alt_oe[i] : oe_q[i];
  end

  // open-drain only drives low; push-pull drives both levels
  always_comb begin
    for (int k = 0; k < gpm_pkg::NUM_PINS; k++) begin
      pad_out[k] = od_q[k] ? 1'b0 : drv_val[k];
      pad_oe[k] = drv_oe[k] & (~od_q[k] | ~drv_val[k]);
    end
  end

  // peripheral inputs from pins, selected per function
  always_comb begin
    spi_rxd = 1'b1;
    serial_clock_input = 1'b0;
    spi_fs_in = 1'b1;
    dbg_data_in = 1'b1;
    uart_rxd = 1'b1;
    dbg_clk_in = 1'b0;
    if (fsel_q[2*gpm_pkg::PIN_SPI_RXD +: 2] == 2'h1)
      spi_rxd = pin_in[gpm_pkg::PIN_SPI_RXD];
    if (fsel_q[2*gpm_pkg::PIN_SPI_CLKI +: 2] == 2'h1)
      serial_clock_input = pin_in[gpm_pkg::PIN_SPI_CLKI];
    if (fsel_q[2*gpm_pkg::PIN_SPI_FSI +: 2] == 2'h1)
      spi_fs_in = pin_in[gpm_pkg::PIN_SPI_FSI];
    if (fsel_q[2*gpm_pkg::PIN_DBG_DATA +: 2] == 2'h1)
      dbg_data_in = pin_in[gpm_pkg::PIN_DBG_DATA];
    // pin 0 wins if both are selected
    if (fsel_q[2*gpm_pkg::PIN_UART_RX_B +: 2] == 2'h2)
      uart_rxd = pin_in[gpm_pkg::PIN_UART_RX_B];
    if (fsel_q[2*gpm_pkg::PIN_UART_RX_A +: 2] == 2'h2)
      uart_rxd = pin_in[gpm_pkg::PIN_UART_RX_A];
    if (fsel_q[2*gpm_pkg::PIN_DBG_CLK +: 2] == 2'h2)
      dbg_clk_in = pin_in[gpm_pkg::PIN_DBG_CLK];
    // select three feeds no peripheral input
  end

  // software read-back and pad controls
  assign in_rdata = in_q;
  assign out_rdata = out_q;
  assign oe_rdata = oe_q;
  assign ie_rdata = ie_q;
  assign pu_rdata = pu_q;
  assign pd_rdata = pd_q;
  assign od_rdata = od_q;
  assign fsel_rdata = fsel_q;
  assign pad_pu_en = pu_q;
  assign pad_pd_en = pd_q;
  assign pad_ie = ie_q;

  // input stage off reads one next cycle
  chk_disabled_reads_one: assert property (!ie_q[3] |=> in_rdata[3])
    else $error("disabled input not one");
  // open drain never drives high
  chk_od_no_high: assert property (
    od_q[1] && pad_oe[1] |-> !pad_out[1])
    else $error("od drove high");
  // primary drive follows output bit
  chk_primary_drive: assert property (
    fsel_q[1:0] == 2'h0 && !od_q[0] |-> pad_out[0] == out_q[0])
    else $error("primary value wrong");
  // primary enable follows software
  chk_primary_oe: assert property (
    fsel_q[9:8] == 2'h0 && !od_q[4] |-> pad_oe[4] == oe_q[4])
    else $error("primary enable wrong");
  // write lands next cycle
  chk_out_write: assert property (
    out_wr |=> out_rdata == $past(out_wdata))
    else $error("write lost");
  // pwm on pin 2
  chk_pwm_route: assert property (
    fsel_q[5:4] == 2'h3 && !od_q[2] |-> pad_out[2] == pwm_out)
    else $error("pwm route wrong");
  // uart tx on pin 0
  chk_uart_route: assert property (
    fsel_q[1:0] == 2'h2 && !od_q[0] |-> pad_oe[0] == uart_txd_oe)
    else $error("uart route wrong");
  // debug data on pin 6
  chk_dbg_route: assert property (
    fsel_q[13:12] == 2'h1 && !od_q[6] |-> pad_out[6] == dbg_data_out)
    else $error("debug route wrong");
  // spi clock in from pin 4
  chk_serial_clock_input: assert property (
    fsel_q[9:8] == 2'h1 && ie_q[4] |-> serial_clock_input == pad_in[4])
    else $error("spi clock in wrong");
  // uart receive from pin 2 when pin 0 does not claim it
  chk_uart_rx_b: assert property (
    fsel_q[5:4] == 2'h2 && fsel_q[1:0] != 2'h2 |-> uart_rxd == pin_in[2])
    else $error("uart rx route wrong");
  // select three feeds no peripheral input
  chk_alt3_no_input: assert property (
    fsel_q[11:10] == 2'h3 |-> !dbg_clk_in && spi_fs_in)
    else $error("alt three fed input");
  // after reset: primary, driver off, pulls off
  chk_reset_off: assert property (disable iff (1'b0)
    $past(rst) |-> pad_oe == 7'h00 && pad_pu_en == 7'h00 &&
    pad_pd_en == 7'h00 && fsel_q == gpm_pkg::RST_FSEL)
    else $error("reset state wrong");
endmodule

// ==== include/gpm_pkg.sv ====
// constants and types for the seven-pin port with alternate functions
package gpm_pkg;
  localparam int NUM_PINS = 7;
  localparam int FSEL_W = 2;
  // function select codes
  typedef enum logic [1:0] {
    GPM_FN_PRIMARY = 2'h0,
    GPM_FN_ALT1 = 2'h1,
    GPM_FN_ALT2 = 2'h2,
    GPM_FN_ALT3 = 2'h3
  } gpm_fsel_t;
  // pin positions of the alternate connections
  localparam int PIN_SPI_TXD = 0;
  localparam int PIN_SPI_CLKO = 1;
  localparam int PIN_SPI_FSO = 3;
  localparam int PIN_DBG_DATA = 6;
  localparam int PIN_UART_TX_A = 0;
  localparam int PIN_UART_TX_B = 2;
  localparam int PIN_PWM_LAST = 2;
  localparam int PIN_SPI_RXD = 2;
  localparam int PIN_SPI_CLKI = 4;
  localparam int PIN_SPI_FSI = 5;
  localparam int PIN_UART_RX_A = 0;
  localparam int PIN_UART_RX_B = 2;
  localparam int PIN_DBG_CLK = 5;
  // reset values
  localparam logic [6:0] RST_OUT = 7'h00;
  localparam logic [6:0] RST_OE = 7'h00;
  localparam logic [6:0] RST_IE = 7'h7F;
  localparam logic [6:0] RST_IN = 7'h7F;
  localparam logic [6:0] RST_PULL = 7'h00;
  localparam logic [6:0] RST_OD = 7'h00;
  localparam logic [13:0] RST_FSEL = 14'h0000;
endpackage

// ==== tb/gpm_pad_model.sv ====
// board side of the pins: own drive, board drive, pulls, else wandering
module gpm_pad_model (
  input wire logic clk,
  input wire logic [6:0] pad_out,
  input wire logic [6:0] pad_oe,
  input wire logic [6:0] pad_pu_en,
  input wire logic [6:0] pad_pd_en,
  input wire logic [6:0] ext_en,
  input wire logic [6:0] ext_val,
  output logic [6:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog = 1'b0;
  // a floating line changes every cycle so a stale level never passes
  always @(posedge clk) begin
    tog <= ~tog;
  end
  // wire level per pin
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pu_en[i]) pad_in[i] = 1'b1;
      else if (pad_pd_en[i]) pad_in[i] = 1'b0;
      else pad_in[i] = tog;
    end
  end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the seven-pin port
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst;
  logic [6:0] wr, ext_en, ext_val, pin, pout, poe, pu, pd, pie;
  logic [13:0] wd, fs_rd;
  logic [11:0] pv;
  logic [5:0] pi;
  logic [6:0] in_rd, out_rd, oe_rd, ie_rd, pu_rd, pd_rd, od_rd;
  int err_total, total_checks;
  gpm_port u_gpm_port (.clk(clk), .rst(rst),
    .out_wr(wr[0]), .out_wdata(wd[6:0]), .oe_wr(wr[1]), .oe_wdata(wd[6:0]),
    .ie_wr(wr[2]), .ie_wdata(wd[6:0]), .pu_wr(wr[3]), .pu_wdata(wd[6:0]),
    .pd_wr(wr[4]), .pd_wdata(wd[6:0]), .od_wr(wr[5]), .od_wdata(wd[6:0]),
    .fsel_wr(wr[6]), .fsel_wdata(wd), .in_rdata(in_rd), .out_rdata(out_rd),
    .oe_rdata(oe_rd), .ie_rdata(ie_rd), .pu_rdata(pu_rd), .pd_rdata(pd_rd),
    .od_rdata(od_rd), .fsel_rdata(fs_rd), .pad_in(pin), .pad_out(pout),
    .pad_oe(poe), .pad_pu_en(pu), .pad_pd_en(pd), .pad_ie(pie),
    .spi_txd(pv[0]), .spi_txd_oe(pv[1]), .spi_clk_out(pv[2]),
    .spi_clk_oe(pv[3]), .spi_fs_out(pv[4]), .spi_fs_oe(pv[5]),
    .dbg_data_out(pv[6]), .dbg_data_oe(pv[7]), .uart_txd(pv[8]),
    .uart_txd_oe(pv[9]), .pwm_out(pv[10]), .pwm_oe(pv[11]),
    .spi_rxd(pi[5]), .serial_clock_input(pi[4]), .spi_fs_in(pi[3]),
    .dbg_data_in(pi[2]), .uart_rxd(pi[1]), .dbg_clk_in(pi[0]));
  gpm_pad_model u_gpm_pad_model (.clk(clk), .pad_out(pout), .pad_oe(poe),
    .pad_pu_en(pu), .pad_pd_en(pd), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pin));
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // compare one value
  task automatic check(input string nm, input logic [13:0] seen,
                       input logic [13:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one-cycle write strobe of control word k
  task automatic wr_reg(input int k, input logic [13:0] d);
    @(negedge clk);
    wr = 7'h01 << k;
    wd = d;
    @(negedge clk);
    wr = 7'h00;
  endtask
  // verdict
  task automatic finish_test();
    if (err_total == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    finish_test();
  end
  // main sequence
  initial begin
    rst = 1'b1;
    wr = 7'h00;
    wd = 14'h0000;
    pv = 12'h000;
    ext_en = 7'h7F;
    ext_val = 7'h2A;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check("oe_rd", {7'h00, oe_rd}, 14'h0000);
    check("pad_oe", {7'h00, poe}, 14'h0000);
    check("fsel", fs_rd, 14'h0000);
    check("pulls", {pu, pd}, 14'h0000);
    check("ie_rd", {7'h00, ie_rd}, 14'h007F);
    // primary drive and read back
    wr_reg(1, 14'h007F);
    wr_reg(0, 14'h0055);
    @(negedge clk);
    check("pad_out", {7'h00, pout}, 14'h0055);
    check("out_rd", {7'h00, out_rd}, 14'h0055);
    check("pad_oe", {7'h00, poe}, 14'h007F);
    check("in_rd", {7'h00, in_rd}, 14'h0055);
    // input stage off reads ones
    wr_reg(1, 14'h0000);
    wr_reg(2, 14'h0000);
    @(negedge clk);
    check("in_off", {7'h00, in_rd}, 14'h007F);
    check("pad_ie", {7'h00, pie}, 14'h0000);
    wr_reg(2, 14'h007F);
    @(negedge clk);
    check("in_on", {7'h00, in_rd}, 14'h002A);
    // pulls
    wr_reg(3, 14'h000F);
    wr_reg(4, 14'h0070);
    check("pad_pu", {7'h00, pu}, 14'h000F);
    check("pad_pd", {7'h00, pd}, 14'h0070);
    check("pu_rd", {7'h00, pu_rd}, 14'h000F);
    check("pd_rd", {7'h00, pd_rd}, 14'h0070);
    // board lets go: the pulls alone set the undriven lines
    ext_en = 7'h00;
    @(negedge clk);
    check("pulled_in", {7'h00, in_rd}, 14'h000F);
    ext_en = 7'h7F;
    // open drain
    wr_reg(1, 14'h007F);
    wr_reg(5, 14'h007F);
    wr_reg(0, 14'h0055);
    check("od_oe", {7'h00, poe}, 14'h002A);
    check("od_out", {7'h00, pout & poe}, 14'h0000);
    check("od_rd", {7'h00, od_rd}, 14'h007F);
    wr_reg(5, 14'h0000);
    // alternate one
    wr_reg(6, 14'h1555);
    pv = 12'h03E;
    ext_val = 7'h74;
    @(negedge clk);
    check("a1_oe", {7'h00, poe}, 14'h000B);
    check("a1_out", {7'h00, pout & poe}, 14'h000A);
    check("a1_in", {8'h00, pi}, 14'h003E);
    ext_val = 7'h00;
    @(negedge clk);
    check("a1_in0", {8'h00, pi}, 14'h0002);
    check("fsel_rd", fs_rd, 14'h1555);
    // alternate two
    wr_reg(6, 14'h2AAA);
    pv = 12'h200;
    ext_val = 7'h20;
    @(negedge clk);
    check("a2_oe", {7'h00, poe}, 14'h0005);
    check("a2_out", {7'h00, pout & poe}, 14'h0000);
    check("a2_in", {8'h00, pi}, 14'h002D);
    pv = 12'h300;
    @(negedge clk);
    check("a2_out1", {7'h00, pout & poe}, 14'h0005);
    // uart receive from pin 2 alone
    pv = 12'h200;
    wr_reg(6, 14'h0020);
    @(negedge clk);
    check("a2_rx_b", {8'h00, pi}, 14'h002C);
    // alternate three
    wr_reg(6, 14'h3FFF);
    pv = 12'hC00;
    ext_val = 7'h7F;
    @(negedge clk);
    check("a3_oe", {7'h00, poe}, 14'h0007);
    check("a3_out", {7'h00, pout & poe}, 14'h0007);
    check("a3_in", {8'h00, pi}, 14'h002E);
    finish_test();
  end
endmodule
